/* rtl/fspc_flash_self_program_controller.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Row holds 64 instructions; program writes one row.
// - Erase removes eight rows, 512 instructions, at once.
// - Double-word program writes just two instructions.
// - Erase aligned 1536 bytes, rows aligned 192 bytes.
// - Table writes fill latches; array changes only later.
// - Any latch count programs; full row needs 64.
// - Latches load in any order; newest write wins.
// - A latch write is a two-cycle single word.
// - Operation on executing partition stalls the processor.
// - Start bit launches operation; hardware clears it after.
// - Inactive-partition operations do not stall the processor.
// - Low word, high byte address; fixed erases ignore.
// - Permit bit zero inhibits all program and erase.
// - Error flag set on bad sequence or termination.
// - Idle power-down bit cuts flash power in Idle.
// - Swap status set after successful swap, dual only.
// - Partition two active status shown in dual only.
// - Start, permit, error, select cleared by power-on only.
// - Select field bits 3:0; undefined codes unimplemented.
// - Codes E, 3 erase; codes 2, 1 program.
// - Code 4 erases inactive partition, dual modes only.
module fspc_flash_self_program_controller
  import fspc_pkg::*;
#(
  parameter int CHIP_ERASE_CYCLES = CHIP_ERASE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic deviceReset,
  input wire logic cpuIdle,
  input wire logic swapInstrDone,
  input wire logic secondPartitionActive,
  input wire logic [1:0] bootPartitionMode,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output fspc_cmd_t flashCmd,
  output logic cpuStall,
  output logic flashPowerDown
);

  // Latch array has no reset: its content is undefined until loaded.
  logic [23:0] latchMem [ROW_WORDS];
  logic [5:0] latchIndex_q;
  logic latchPhase_q;
  logic ack_q;
  logic [31:0] rdData_q;
  logic start_q;
  logic permit_q;
  logic error_q;
  logic idlePd_q;
  logic swapDone_q;
  logic [3:0] opSel_q;
  logic [15:0] addrLow_q;
  logic [7:0] addrHigh_q;
  fspc_key_t key_q;
  fspc_state_t state_q;
  logic [5:0] streamIdx_q;
  logic [15:0] timer_q;
  logic [3:0] runOp_q;
  logic [23:0] runBase_q;
  logic runInactive_q;
  fspc_cmd_t cmd_q;
  logic stall_q;
  logic powerDown_q;

  // Bus decode; latch data writes take one extra wait cycle.
  wire busReq = wb_cyc_i & wb_stb_i;
  wire selLatchData = (wb_adr_i == OFF_LATCH_DATA);
  wire ackNext = busReq & ~ack_q & (~(selLatchData & wb_we_i) | latchPhase_q);
  wire wrTake = busReq & wb_we_i & ack_q;
  wire loLane = wb_sel_i[0];
  wire hiLane = wb_sel_i[1];
  wire upLane = wb_sel_i[2];
  wire wrControl = wrTake & (wb_adr_i == OFF_CONTROL);
  wire wrKey = wrTake & (wb_adr_i == OFF_UNLOCK_KEY) & loLane;
  wire wrAddrLow = wrTake & (wb_adr_i == OFF_DEST_ADDR_LOW);
  wire wrAddrHigh = wrTake & (wb_adr_i == OFF_DEST_ADDR_HIGH) & loLane;
  wire wrLatchIndex = wrTake & (wb_adr_i == OFF_LATCH_INDEX) & loLane;
  wire wrLatchData = wrTake & selLatchData;

  // Mode and target decode.
  wire dualMode = (bootPartitionMode != MODE_SINGLE);
  wire [3:0] newOp = loLane ? wb_dat_i[3:0] : opSel_q;
  wire newPermit = hiLane ? wb_dat_i[CTL_PERMIT] : permit_q;
  wire opValid = (newOp == OP_CHIP_ERASE) | (newOp == OP_PAGE_ERASE) |
                 (newOp == OP_ROW_PROG) | (newOp == OP_DWORD_PROG) |
                 ((newOp == OP_INACTIVE_ERASE) & dualMode);
  wire startAttempt = wrControl & hiLane & wb_dat_i[CTL_START];
  wire idle = (state_q == ST_IDLE);
  wire goodStart = startAttempt & idle & newPermit & (key_q == KEY_OPEN) & opValid;
  wire badStart = startAttempt & ~goodStart;
  wire [23:0] destAddr = {addrHigh_q, addrLow_q};
  wire newInactive = dualMode & ((newOp == OP_INACTIVE_ERASE) |
                     ((newOp != OP_CHIP_ERASE) &
                     (destAddr[INACTIVE_ADDR_BIT] != secondPartitionActive)));
  wire isErase = (newOp == OP_CHIP_ERASE) | (newOp == OP_PAGE_ERASE) |
                 (newOp == OP_INACTIVE_ERASE);
  wire swapSet = swapInstrDone & dualMode;
  wire swapClr = wrControl & hiLane & ~wb_dat_i[CTL_SWAP];

  // Base address aligned to the unit that each operation covers.
  wire [23:0] rowBase = {destAddr[23:ROW_ALIGN_BITS], {ROW_ALIGN_BITS{1'b0}}};
  wire [23:0] dwordBase = {destAddr[23:DWORD_ALIGN_BITS], {DWORD_ALIGN_BITS{1'b0}}};
  wire [23:0] eraseBase = {destAddr[23:ERASE_ALIGN_BITS], {ERASE_ALIGN_BITS{1'b0}}};
  wire [23:0] newBase = (newOp == OP_ROW_PROG) ? rowBase :
                        (newOp == OP_DWORD_PROG) ? dwordBase :
                        (newOp == OP_PAGE_ERASE) ? eraseBase : ADDR_RESET;
  wire [5:0] streamLast = (runOp_q == OP_ROW_PROG) ? ROW_LAST : DWORD_LAST;
  wire [15:0] opCycles = (runOp_q == OP_ROW_PROG) ? 16'(ROW_PROG_CYC) :
                         (runOp_q == OP_DWORD_PROG) ? 16'(DWORD_PROG_CYC) :
                         (runOp_q == OP_PAGE_ERASE) ? 16'(PAGE_ERASE_CYC) :
                         16'(CHIP_ERASE_CYCLES);
  wire [23:0] streamAddr = runBase_q + {17'h00000, streamIdx_q, 1'b0};

  // Read view of flash_control; swap and partition bits exist only in dual mode.
  wire [15:0] controlView = {start_q, permit_q, error_q, idlePd_q,
                             swapDone_q & dualMode, secondPartitionActive & dualMode,
                             6'h00, opSel_q};
  wire [31:0] readMux = (wb_adr_i == OFF_CONTROL) ? {16'h0000, controlView} :
                        (wb_adr_i == OFF_DEST_ADDR_LOW) ? {16'h0000, addrLow_q} :
                        (wb_adr_i == OFF_DEST_ADDR_HIGH) ? {24'h000000, addrHigh_q} :
                        (wb_adr_i == OFF_LATCH_INDEX) ? {26'h0000000, latchIndex_q} :
                        32'h00000000;

  // Bus handshake; an unmapped address is acknowledged and reads zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      latchPhase_q <= 1'b0;
      rdData_q <= 32'h00000000;
    end else if (clkEn) begin
      ack_q <= ackNext;
      latchPhase_q <= busReq & selLatchData & wb_we_i & ~ack_q & ~latchPhase_q;
      if (ackNext) begin
        rdData_q <= readMux;
      end
    end
  end

  // Latches hold table writes; the array itself is untouched here.
  always_ff @(posedge core_clk) begin
    if (clkEn && wrLatchData) begin
      latchMem[latchIndex_q] <= {upLane ? wb_dat_i[23:16] : latchMem[latchIndex_q][23:16],
                                 hiLane ? wb_dat_i[15:8] : latchMem[latchIndex_q][15:8],
                                 loLane ? wb_dat_i[7:0] : latchMem[latchIndex_q][7:0]};
    end
  end

  // Latch pointer and destination address; cleared by any reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n || (clkEn && deviceReset)) begin
      latchIndex_q <= 6'h00;
      addrLow_q <= 16'h0000;
      addrHigh_q <= 8'h00;
    end else if (clkEn) begin
      if (wrLatchIndex) begin
        latchIndex_q <= wb_dat_i[5:0];
      end
      if (wrAddrLow && loLane) begin
        addrLow_q[7:0] <= wb_dat_i[7:0];
      end
      if (wrAddrLow && hiLane) begin
        addrLow_q[15:8] <= wb_dat_i[15:8];
      end
      if (wrAddrHigh) begin
        addrHigh_q <= wb_dat_i[7:0];
      end
    end
  end

  // Unlock tracker; any other write in between breaks the sequence.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      key_q <= KEY_NONE;
    end else if (clkEn && wrTake) begin
      if (wrKey && wb_dat_i[7:0] == KEY_FIRST) begin
        key_q <= KEY_HALF;
      end else if (wrKey && wb_dat_i[7:0] == KEY_SECOND && key_q == KEY_HALF) begin
        key_q <= KEY_OPEN;
      end else begin
        key_q <= KEY_NONE;
      end
    end
  end

  // Control bits kept across device resets; only power-on clears them.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      permit_q <= CONTROL_RESET[CTL_PERMIT];
      error_q <= CONTROL_RESET[CTL_ERROR];
      opSel_q <= CONTROL_RESET[3:0];
    end else if (clkEn) begin
      if (wrControl && hiLane) begin
        permit_q <= wb_dat_i[CTL_PERMIT];
      end
      if (wrControl && loLane && idle) begin
        opSel_q <= wb_dat_i[3:0];
      end
      if (badStart || (deviceReset && !idle)) begin
        error_q <= 1'b1;
      end else if (goodStart) begin
        error_q <= 1'b0;
      end
    end
  end

  // Idle power-down and swap status; a swap event wins over a clear.
  always_ff @(posedge core_clk) begin
    if (!rst_n || (clkEn && deviceReset)) begin
      idlePd_q <= CONTROL_RESET[CTL_IDLE_PD];
      swapDone_q <= CONTROL_RESET[CTL_SWAP];
    end else if (clkEn) begin
      if (wrControl && hiLane) begin
        idlePd_q <= wb_dat_i[CTL_IDLE_PD];
      end
      if (swapSet) begin
        swapDone_q <= 1'b1;
      end else if (swapClr) begin
        swapDone_q <= 1'b0;
      end
    end
  end

  // Sequencer: stream latches or issue erase, then wait out the self-timed period.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      streamIdx_q <= 6'h00;
      timer_q <= 16'h0000;
      runOp_q <= 4'h0;
      runBase_q <= ADDR_RESET;
      runInactive_q <= 1'b0;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          if (goodStart) begin
            start_q <= 1'b1;
            runOp_q <= newOp;
            runBase_q <= newBase;
            runInactive_q <= newInactive;
            streamIdx_q <= 6'h00;
            state_q <= isErase ? ST_ERASE : ST_STREAM;
          end
        end
        ST_STREAM: begin
          if (deviceReset) begin
            state_q <= ST_DONE;
          end else if (streamIdx_q == streamLast) begin
            timer_q <= opCycles;
            state_q <= ST_WAIT;
          end else begin
            streamIdx_q <= streamIdx_q + 6'h01;
          end
        end
        ST_ERASE: begin
          timer_q <= opCycles;
          state_q <= deviceReset ? ST_DONE : ST_WAIT;
        end
        ST_WAIT: begin
          if (deviceReset || timer_q <= 16'h0001) begin
            state_q <= ST_DONE;
          end else begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        ST_DONE: begin
          start_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered outputs toward the array, the core and the power controller.
  // Stalling covers the whole operation so code never fetches from a busy array.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_q <= '0;
      stall_q <= 1'b0;
      powerDown_q <= 1'b0;
    end else if (clkEn) begin
      cmd_q.program_permit <= (state_q == ST_STREAM) & ~deviceReset;
      cmd_q.eraseEn <= (state_q == ST_ERASE) & ~deviceReset;
      cmd_q.op <= runOp_q;
      cmd_q.addr <= (state_q == ST_STREAM) ? streamAddr : runBase_q;
      cmd_q.data <= latchMem[streamIdx_q];
      stall_q <= (goodStart & ~newInactive) |
                 (~idle & (state_q != ST_DONE) & ~runInactive_q);
      powerDown_q <= cpuIdle & idlePd_q & idle;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdData_q;
  assign flashCmd = cmd_q;
  assign cpuStall = stall_q;
  assign flashPowerDown = powerDown_q;

  // Helper count of words streamed during one operation.
  logic [6:0] wordCount_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n || (clkEn && goodStart)) begin
      wordCount_q <= 7'h00;
    end else if (clkEn && cmd_q.program_permit) begin
      wordCount_q <= wordCount_q + 7'h01;
    end
  end

  // A latch data write sees one wait state, then a single acknowledge.
  sequence latchWriteReq;
    busReq && wb_we_i && selLatchData && !ack_q && !latchPhase_q;
  endsequence
  sequence waitOneThenAck;
    !wb_ack_o ##1 wb_ack_o;
  endsequence

  chk_bad_start_error: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && badStart) |=> (error_q && (idle || state_q == $past(state_q))))
    else $error("bad start did not raise error");
  chk_good_start_runs: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && goodStart) |=> (start_q && !idle && !error_q))
    else $error("good start did not launch");
  chk_stream_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && state_q == ST_DONE && runOp_q == OP_ROW_PROG && !$past(deviceReset)) |->
    (wordCount_q == 7'(ROW_WORDS)))
    else $error("row program did not stream 64 words");
  chk_dword_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && state_q == ST_DONE && runOp_q == OP_DWORD_PROG && !$past(deviceReset)) |->
    (wordCount_q == 7'h02))
    else $error("double-word program streamed wrong count");
  chk_erase_align: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flashCmd.eraseEn && flashCmd.op == OP_PAGE_ERASE) |-> (flashCmd.addr[9:0] == 10'h000))
    else $error("page erase address not aligned");
  chk_stall_inactive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && goodStart && newInactive) |=> !cpuStall [*2])
    else $error("inactive partition operation stalled core");
  chk_stall_active: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && goodStart && !newInactive) |=> cpuStall ##1 cpuStall)
    else $error("active partition operation did not stall");
  chk_permit_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(start_q) |-> $past(newPermit))
    else $error("operation started while inhibited");
  chk_latch_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    (latchWriteReq and clkEn) ##1 clkEn |-> waitOneThenAck)
    else $error("latch write not two cycles");
  // Erase strobes only ever carry one of the erase codes.
  chk_erase_codes: assert property (@(posedge core_clk) disable iff (!rst_n)
    flashCmd.eraseEn |-> (flashCmd.op == OP_CHIP_ERASE || flashCmd.op == OP_PAGE_ERASE ||
    flashCmd.op == OP_INACTIVE_ERASE))
    else $error("erase strobe with a program code");
  chk_swap_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!dualMode) |-> (controlView[CTL_SWAP] == 1'b0 && controlView[CTL_P2] == 1'b0))
    else $error("partition bits visible in single mode");
  chk_unimpl_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    controlView[9:4] == 6'h00)
    else $error("unimplemented control bits not zero");

endmodule // fspc_flash_self_program_controller

/* rtl/fspc_pkg.sv */
package fspc_pkg;

  // Word-aligned register byte offsets on the register bus.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h04;
  localparam logic [7:0] OFF_DEST_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_DEST_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFF_LATCH_INDEX = 8'h10;
  localparam logic [7:0] OFF_LATCH_DATA = 8'h14;

  // Field positions inside flash_control.
  localparam int CTL_START = 15;
  localparam int CTL_PERMIT = 14;
  localparam int CTL_ERROR = 13;
  localparam int CTL_IDLE_PD = 12;
  localparam int CTL_SWAP = 11;
  localparam int CTL_P2 = 10;

  // Operation select codes.
  localparam logic [3:0] OP_CHIP_ERASE = 4'hE;
  localparam logic [3:0] OP_INACTIVE_ERASE = 4'h4;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_ROW_PROG = 4'h2;
  localparam logic [3:0] OP_DWORD_PROG = 4'h1;

  // Unlock key bytes, in the order they must arrive.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Array geometry; addresses count two units per instruction.
  localparam int ROW_WORDS = 64;
  localparam int ROW_BYTES = 192;
  localparam int ERASE_WORDS = 512;
  localparam int ERASE_BYTES = 1536;
  localparam int ROW_ALIGN_BITS = 7;
  localparam int ERASE_ALIGN_BITS = 10;
  localparam int DWORD_ALIGN_BITS = 2;
  localparam logic [5:0] ROW_LAST = 6'h3F;
  localparam logic [5:0] DWORD_LAST = 6'h01;
  localparam int INACTIVE_ADDR_BIT = 22;
  localparam logic [1:0] MODE_SINGLE = 2'h3;

  // Reset values.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [23:0] ADDR_RESET = 24'h000000;

  // Self-timed operation lengths and their cycle counts.
  localparam int CLK_PERIOD_NS = 40;
  localparam int ROW_PROG_TIME_NS = 2000;
  localparam int DWORD_PROG_TIME_NS = 400;
  localparam int PAGE_ERASE_TIME_NS = 20000;
  localparam int CHIP_ERASE_TIME_NS = 400000;
  localparam int ROW_PROG_CYC = (ROW_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWORD_PROG_CYC = (DWORD_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_ERASE_CYC = (PAGE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_ERASE_CYC = (CHIP_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STREAM = 3'b001,
    ST_ERASE = 3'b010,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b100
  } fspc_state_t;

  typedef enum logic [1:0] {
    KEY_NONE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } fspc_key_t;

  // Command toward the flash array macro.
  typedef struct packed {
    logic program_permit;
    logic eraseEn;
    logic [3:0] op;
    logic [23:0] addr;
    logic [23:0] data;
  } fspc_cmd_t;

endpackage

/* sim/flash_self_program_controller_tb.sv */
`timescale 1ns/1ps
module flash_self_program_controller_tb
  import fspc_pkg::*;
;
  localparam int CHIP_CYC = 20;
  logic core_clk, rst_n, devRst, cpuIdle, swapDone, secAct;
  logic [1:0] bootMode;
  logic wbCyc, wbStb, wbWe, ack, cpuStall, flashPowerDown;
  logic [7:0] wbAdr;
  logic [31:0] wbDat, rdDat;
  fspc_cmd_t flashCmd;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [23:0] lat [64];
  logic [23:0] a, base;
  int errCount = 0;
  int comparisons = 0;
  int st;

  fspc_flash_self_program_controller #(.CHIP_ERASE_CYCLES(CHIP_CYC)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .deviceReset(devRst), .cpuIdle(cpuIdle),
    .swapInstrDone(swapDone), .secondPartitionActive(secAct), .bootPartitionMode(bootMode),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDat), .wb_dat_o(rdDat), .wb_ack_o(ack), .flashCmd(flashCmd),
    .cpuStall(cpuStall), .flashPowerDown(flashPowerDown));

  fspc_flash_array_model arr (.core_clk(core_clk), .flashCmd(flashCmd));

  // Free-running system clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the request is held until ack is seen high at a rising edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDat <= dat;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errCount++;
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  // Reads only note what is expected; the monitor below does the comparing.
  task automatic rd(input logic [7:0] adr, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    expQ.push_back(e);
    mskQ.push_back(m);
    wb(1'b0, adr, 32'h00000000);
  endtask

  task automatic unlock();
    wb(1'b1, OFF_UNLOCK_KEY, {24'h000000, KEY_FIRST});
    wb(1'b1, OFF_UNLOCK_KEY, {24'h000000, KEY_SECOND});
  endtask

  task automatic start(input logic [3:0] op, input logic [23:0] adr);
    wb(1'b1, OFF_CONTROL, {16'h0000, 12'h400, op});
    wb(1'b1, OFF_DEST_ADDR_LOW, {16'h0000, adr[15:0]});
    wb(1'b1, OFF_DEST_ADDR_HIGH, {24'h000000, adr[23:16]});
    unlock();
    wb(1'b1, OFF_CONTROL, {16'h0000, 12'hC00, op});
  endtask

  // Lets an operation run while counting the cycles in which the core is held.
  task automatic runOp(input int n, output int stalls);
    stalls = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (cpuStall === 1'b1) stalls++;
    end
  endtask

  task automatic setMode(input logic [1:0] m, input logic p2);
    @(posedge core_clk);
    bootMode <= m;
    secAct <= p2;
  endtask

  task automatic pulse(input bit sw);
    @(posedge core_clk);
    if (sw) swapDone <= 1'b1;
    else devRst <= 1'b1;
    @(posedge core_clk);
    swapDone <= 1'b0;
    devRst <= 1'b0;
  endtask

  // The oldest expected read value is matched at the edge where ack is sampled high.
  always @(posedge core_clk) begin
    if (ack === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
      check(rdDat & mskQ.pop_front(), expQ.pop_front());
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge core_clk);
    errCount++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    devRst = 1'b0;
    cpuIdle = 1'b0;
    swapDone = 1'b0;
    secAct = 1'b0;
    bootMode = MODE_SINGLE;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDat = 32'h00000000;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    void'($urandom(97));
    rd(OFF_CONTROL, 32'h00000000);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h00000000);
    rd(OFF_UNLOCK_KEY, 32'h00000000);
    wb(1'b1, OFF_CONTROL, 32'h00007FF2);
    rd(OFF_CONTROL, 32'h00005002);
    wb(1'b1, OFF_CONTROL, 32'h0000C002);
    rd(OFF_CONTROL, 32'h00006002);
    wb(1'b1, OFF_CONTROL, 32'h00000002);
    unlock();
    wb(1'b1, OFF_CONTROL, 32'h00008002);
    rd(OFF_CONTROL, 32'h00002002);
    wb(1'b1, OFF_CONTROL, 32'h00004002);
    unlock();
    wb(1'b1, OFF_DEST_ADDR_LOW, 32'h00000000);
    wb(1'b1, OFF_CONTROL, 32'h0000C002);
    rd(OFF_CONTROL, 32'h00006002);
    unlock();
    wb(1'b1, OFF_CONTROL, 32'h0000C007);
    rd(OFF_CONTROL, 32'h00006000, 32'h0000E000);
    unlock();
    wb(1'b1, OFF_CONTROL, 32'h0000C004);
    rd(OFF_CONTROL, 32'h00006000, 32'h0000E000);
    check(arr.writeCount + arr.eraseCount, 0);
    // Whole row loaded from the top down, then one latch rewritten.
    for (int i = 63; i >= 0; i--) begin
      lat[i] = 24'($urandom());
      wb(1'b1, OFF_LATCH_INDEX, i);
      wb(1'b1, OFF_LATCH_DATA, {8'h00, lat[i]});
    end
    lat[5] = 24'($urandom());
    wb(1'b1, OFF_LATCH_INDEX, 32'h00000005);
    wb(1'b1, OFF_LATCH_DATA, {8'h00, lat[5]});
    rd(OFF_LATCH_DATA, 32'h00000000);
    check(arr.writeCount, 0);
    a = 24'($urandom()) & 24'h3FFFFF;
    base = a & 24'hFFFF80;
    start(OP_ROW_PROG, a);
    runOp(ROW_WORDS + ROW_PROG_CYC + 16, st);
    check(32'(st >= ROW_WORDS + ROW_PROG_CYC), 32'h00000001);
    check(arr.writeCount, ROW_WORDS);
    for (int i = 0; i < 64; i++) check(arr.mem[24'(base + 2 * i)], lat[i]);
    rd(OFF_CONTROL, 32'h00004002);
    // Two words into the inactive partition of a dual-partition part.
    setMode(2'h2, 1'b1);
    for (int i = 0; i < 2; i++) begin
      lat[i] = 24'($urandom());
      wb(1'b1, OFF_LATCH_INDEX, i);
      wb(1'b1, OFF_LATCH_DATA, {8'h00, lat[i]});
    end
    a = 24'($urandom()) & 24'h3FFFFF;
    base = a & 24'hFFFFFC;
    start(OP_DWORD_PROG, a);
    runOp(DWORD_PROG_CYC + 24, st);
    check(st, 0);
    check(arr.writeCount, ROW_WORDS + 2);
    check(arr.mem[base], lat[0]);
    check(arr.mem[base + 24'h000002], lat[1]);
    rd(OFF_CONTROL, 32'h00004401);
    setMode(MODE_SINGLE, 1'b0);
    a = 24'($urandom()) & 24'h3FFFFF;
    start(OP_PAGE_ERASE, a);
    runOp(PAGE_ERASE_CYC + 16, st);
    check(32'(st >= PAGE_ERASE_CYC), 32'h00000001);
    check(arr.eraseCount, 1);
    check(arr.lastEraseAddr, a & 24'hFFFC00);
    rd(OFF_CONTROL, 32'h00004003);
    start(OP_CHIP_ERASE, 24'($urandom()));
    runOp(CHIP_CYC + 16, st);
    check(32'(st > 0), 32'h00000001);
    check(arr.lastEraseAddr, 24'h000000);
    rd(OFF_CONTROL, 32'h0000400E);
    setMode(2'h0, 1'b0);
    start(OP_INACTIVE_ERASE, 24'($urandom()));
    runOp(CHIP_CYC + 16, st);
    check(st, 0);
    check(arr.eraseCount, 3);
    check(arr.lastEraseAddr, 24'h000000);
    rd(OFF_CONTROL, 32'h00004004);
    pulse(1'b1);
    rd(OFF_CONTROL, 32'h00000800, 32'h00000800);
    wb(1'b1, OFF_CONTROL, 32'h00004004);
    rd(OFF_CONTROL, 32'h00004004);
    pulse(1'b1);
    pulse(1'b0);
    rd(OFF_CONTROL, 32'h00004004);
    // A device reset in mid-row terminates the operation.
    setMode(MODE_SINGLE, 1'b0);
    start(OP_ROW_PROG, 24'h000000);
    runOp(20, st);
    pulse(1'b0);
    runOp(8, st);
    rd(OFF_CONTROL, 32'h00006000, 32'h0000E000);
    wb(1'b1, OFF_CONTROL, 32'h00005002);
    @(posedge core_clk);
    cpuIdle <= 1'b1;
    runOp(4, st);
    check(flashPowerDown, 1'b1);
    wb(1'b1, OFF_CONTROL, 32'h00004002);
    runOp(4, st);
    check(flashPowerDown, 1'b0);
    report_and_stop();
  end
endmodule // flash_self_program_controller_tb

/* sim/fspc_flash_array_model.sv */
`timescale 1ns/1ps
// Behavioural program array that records every word and erase the controller commits.
module fspc_flash_array_model
  import fspc_pkg::*;
(
  input wire logic core_clk,
  input wire fspc_cmd_t flashCmd
);
  logic [23:0] mem [logic [23:0]];
  int writeCount = 0;
  int eraseCount = 0;
  logic [23:0] lastEraseAddr = 24'h000000;

  // Words land only on a write strobe, so latch traffic alone never shows up here.
  always @(posedge core_clk) begin
    if (flashCmd.program_permit === 1'b1) begin
      mem[flashCmd.addr] = flashCmd.data;
      writeCount++;
    end
    if (flashCmd.eraseEn === 1'b1) begin
      lastEraseAddr = flashCmd.addr;
      eraseCount++;
    end
  end
endmodule // fspc_flash_array_model
